// ==== include/irpic_defs.svh ====
`ifndef IRPIC_DEFS_SVH
`define IRPIC_DEFS_SVH

// Clock and reference oscillator.
`define IRPIC_CLK_MHZ 10
`define IRPIC_REF_OSC_KHZ 480

// Code timing at the reference oscillator, in microseconds; carrier in kHz.
`define IRPIC_T_PULSE_US 500
`define IRPIC_CARRIER_KHZ 40
`define IRPIC_T_ZERO_US 2000
`define IRPIC_T_ONE_US 4000
`define IRPIC_T_WORD_US 48000
`define IRPIC_T_SPLIT_US ((`IRPIC_T_ZERO_US + `IRPIC_T_ONE_US) / 2)
`define IRPIC_T_MIN_US (`IRPIC_T_ZERO_US / 2)
`define IRPIC_T_TIMEOUT_US 6000
`define IRPIC_T_GAP_US 50
`define IRPIC_T_HOLD_US 100000

// Widths.
`define IRPIC_CODE_W 6
`define IRPIC_BITS 3'h6
`define IRPIC_CNT_W 20
`define IRPIC_HOLD_W 30

// Command codes, code_bit_first in bit 0 through code_bit_last in bit 5.
`define IRPIC_CODE_NONE 6'h00
`define IRPIC_CODE_CHAN_INC 6'h01
`define IRPIC_CODE_CHAN_DEC 6'h02
`define IRPIC_CODE_VOL_UP 6'h03
`define IRPIC_CODE_VOL_DN 6'h04
`define IRPIC_CODE_BRT_UP 6'h05
`define IRPIC_CODE_BRT_DN 6'h06
`define IRPIC_CODE_SAT_UP 6'h07
`define IRPIC_CODE_SAT_DN 6'h08
`define IRPIC_CODE_MUTE 6'h09
`define IRPIC_CODE_VOL_THIRD 6'h0a
`define IRPIC_CODE_BRT_HALF 6'h0b
`define IRPIC_CODE_SAT_HALF 6'h0c
`define IRPIC_CODE_CALL 6'h0d
`define IRPIC_CODE_POWER 6'h0e
`define IRPIC_DIRECT_BIT 4
`define IRPIC_HIGH_BIT 5

`endif

// ==== include/irpic_pkg.sv ====
`include "irpic_defs.svh"

package irpic_pkg;

  typedef enum logic [1:0] {
    IRPIC_RX_IDLE = 2'b01,
    IRPIC_RX_RECV = 2'b10
  } irpic_rx_phase_t;

  typedef struct packed {
    logic valid;
    logic [`IRPIC_CODE_W-1:0] code;
  } irpic_word_t;

  typedef struct packed {
    irpic_rx_phase_t phase;
    logic prev_in;
    logic [`IRPIC_CNT_W-1:0] low_cnt;
    logic [`IRPIC_CNT_W-1:0] intv_cnt;
    logic [2:0] nbits;
    logic bad;
    logic [`IRPIC_CODE_W-1:0] code;
    irpic_word_t word;
  } irpic_rx_state_t;

  typedef struct packed {
    logic channel_increment;
    logic channel_decrement;
    logic channel_load;
    logic volume_level_up;
    logic volume_level_down;
    logic brightness_level_up;
    logic brightness_level_down;
    logic saturation_up;
    logic saturation_down;
    logic volume_level_third;
    logic brightness_level_half;
    logic saturation_half;
    logic mute_toggle;
    logic call_toggle;
    logic power_toggle;
  } irpic_cmd_t;

  typedef struct packed {
    logic [`IRPIC_CODE_W-1:0] last_code;
    logic [1:0] match_cnt;
    logic [`IRPIC_HOLD_W-1:0] hold_cnt;
    irpic_cmd_t cmd;
    logic [3:0] channel;
    logic mute;
    logic call;
    logic power;
    logic indicator;
  } irpic_top_state_t;

endpackage

// ==== rtl/irpic_interval_rx.sv ====
`timescale 1ns/10ps
`include "irpic_defs.svh"

module irpic_interval_rx #(
  parameter int unsigned GAP_CYC = `IRPIC_T_GAP_US * `IRPIC_CLK_MHZ,
  parameter int unsigned MIN_CYC = `IRPIC_T_MIN_US * `IRPIC_CLK_MHZ,
  parameter int unsigned SPLIT_CYC = `IRPIC_T_SPLIT_US * `IRPIC_CLK_MHZ,
  parameter int unsigned TIMEOUT_CYC = `IRPIC_T_TIMEOUT_US * `IRPIC_CLK_MHZ
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Conditioned pulse input and assembled word.
  input wire logic pulse_i,
  output irpic_pkg::irpic_word_t word_o
);

  localparam logic [`IRPIC_CNT_W-1:0] GAP = `IRPIC_CNT_W'(GAP_CYC);
  localparam logic [`IRPIC_CNT_W-1:0] MINV = `IRPIC_CNT_W'(MIN_CYC);
  localparam logic [`IRPIC_CNT_W-1:0] SPLIT = `IRPIC_CNT_W'(SPLIT_CYC);
  localparam logic [`IRPIC_CNT_W-1:0] TMO = `IRPIC_CNT_W'(TIMEOUT_CYC);

  irpic_pkg::irpic_rx_state_t st;
  irpic_pkg::irpic_rx_state_t next_st;
  logic pulse_start;

  // A pulse begins only after a quiet time longer than a carrier gap, so a burst
  // that still carries its carrier counts as one pulse.
  assign pulse_start = pulse_i && !st.prev_in && (st.low_cnt >= GAP);

  // Interval measurement and word assembly.
  always_comb begin
    next_st = st;
    next_st.word.valid = 1'b0;
    next_st.prev_in = pulse_i;
    if (pulse_i) begin
      next_st.low_cnt = '0;
    end else if (st.low_cnt < GAP) begin
      next_st.low_cnt = st.low_cnt + 1'b1;
    end
    case (st.phase)
      irpic_pkg::IRPIC_RX_IDLE: begin
        if (pulse_start) begin
          next_st.phase = irpic_pkg::IRPIC_RX_RECV;
          next_st.intv_cnt = '0;
          next_st.nbits = '0;
          next_st.bad = 1'b0;
          next_st.code = '0;
        end
      end
      irpic_pkg::IRPIC_RX_RECV: begin
        if (st.intv_cnt < TMO) begin
          next_st.intv_cnt = st.intv_cnt + 1'b1;
        end
        if (pulse_start) begin
          next_st.intv_cnt = '0;
          if (st.intv_cnt < MINV || st.nbits == `IRPIC_BITS) begin
            next_st.bad = 1'b1;
          end else begin
            next_st.code[st.nbits] = (st.intv_cnt >= SPLIT);
            next_st.nbits = st.nbits + 1'b1;
          end
        end else if (st.intv_cnt >= TMO) begin
          // A long silence closes the word; only six clean intervals pass on.
          next_st.phase = irpic_pkg::IRPIC_RX_IDLE;
          if (st.nbits == `IRPIC_BITS && !st.bad) begin
            next_st.word.valid = 1'b1;
            next_st.word.code = st.code;
          end
        end
      end
      default: begin
        next_st.phase = irpic_pkg::IRPIC_RX_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.phase <= irpic_pkg::IRPIC_RX_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign word_o = st.word;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_word_six_bits: assert property (
    st.word.valid |-> $past(st.nbits) == `IRPIC_BITS && !$past(st.bad))
    else $error("Word passed without exactly six clean intervals.");

  a_bit_class: assert property (
    pulse_start && st.phase == irpic_pkg::IRPIC_RX_RECV && st.intv_cnt >= MINV
      && st.nbits < `IRPIC_BITS
      |=> st.code[$past(st.nbits)] == ($past(st.intv_cnt) >= SPLIT))
    else $error("Interval classified to the wrong bit value.");

endmodule // irpic_interval_rx

// ==== rtl/irpic_receiver.sv ====
// Functional notes
// - A 2 ms pulse spacing is a zero, 4 ms is a one.
// - All timings scale by 480 kHz over the actual oscillator frequency.
// - Pulse intervals are judged into a code passed to the decoder.
// - A command acts only after three identical codes in a row.
// - The all-zero code is ignored entirely.
// - Code 100000 is channel up, 010000 channel down.
// - Codes 110000 to 000100 step volume, brightness and saturation.
// - Code 100100 toggles sound mute.
// - Codes 010100, 110100, 001100 normalize volume, brightness, saturation.
// - Code 101100 toggles the auxiliary call output.
// - Code 011100 toggles the main power output.
// - Codes with fifth bit set, sixth clear, select channel from low four bits.
// - Reception indicator rises once an identical code arrives three times.
`timescale 1ns/10ps
`include "irpic_defs.svh"

module irpic_receiver #(
  parameter int unsigned CLK_MHZ = `IRPIC_CLK_MHZ,
  parameter int unsigned OSC_KHZ = `IRPIC_REF_OSC_KHZ,
  parameter int unsigned MIN_CYC =
    `IRPIC_T_MIN_US * CLK_MHZ * `IRPIC_REF_OSC_KHZ / OSC_KHZ,
  parameter int unsigned SPLIT_CYC =
    `IRPIC_T_SPLIT_US * CLK_MHZ * `IRPIC_REF_OSC_KHZ / OSC_KHZ,
  parameter int unsigned TIMEOUT_CYC =
    `IRPIC_T_TIMEOUT_US * CLK_MHZ * `IRPIC_REF_OSC_KHZ / OSC_KHZ,
  parameter int unsigned HOLD_CYC =
    `IRPIC_T_HOLD_US * CLK_MHZ * `IRPIC_REF_OSC_KHZ / OSC_KHZ
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Conditioned pulse input from the photodetector amplifier.
  input wire logic pulse_in_i,
  // Command pulses, one cycle each.
  output irpic_pkg::irpic_cmd_t cmd_o,
  // Held outputs.
  output logic [3:0] channel_o,
  output logic mute_o,
  output logic call_o,
  output logic power_o,
  output logic reception_indicator_o
);

  // Derived from the reference frequency so a slower oscillator stretches all windows.
  localparam int unsigned GAP_CYC =
    `IRPIC_T_GAP_US * CLK_MHZ * `IRPIC_REF_OSC_KHZ / OSC_KHZ;
  localparam logic [`IRPIC_HOLD_W-1:0] HOLD = `IRPIC_HOLD_W'(HOLD_CYC);

  irpic_pkg::irpic_word_t word;
  irpic_pkg::irpic_top_state_t st;
  irpic_pkg::irpic_top_state_t next_st;

  // Interval receiver; its timeout sits well inside the repeat period of a word.
  irpic_interval_rx #(
    .GAP_CYC(GAP_CYC),
    .MIN_CYC(MIN_CYC),
    .SPLIT_CYC(SPLIT_CYC),
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_rx (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .pulse_i(pulse_in_i),
    .word_o(word)
  );

  // Maps a code to its command pulses.
  function automatic irpic_pkg::irpic_cmd_t decode_cmd(input logic [`IRPIC_CODE_W-1:0] c);
    irpic_pkg::irpic_cmd_t d;
    d = '0;
    case (c)
      `IRPIC_CODE_CHAN_INC: d.channel_increment = 1'b1;
      `IRPIC_CODE_CHAN_DEC: d.channel_decrement = 1'b1;
      `IRPIC_CODE_VOL_UP: d.volume_level_up = 1'b1;
      `IRPIC_CODE_VOL_DN: d.volume_level_down = 1'b1;
      `IRPIC_CODE_BRT_UP: d.brightness_level_up = 1'b1;
      `IRPIC_CODE_BRT_DN: d.brightness_level_down = 1'b1;
      `IRPIC_CODE_SAT_UP: d.saturation_up = 1'b1;
      `IRPIC_CODE_SAT_DN: d.saturation_down = 1'b1;
      `IRPIC_CODE_MUTE: d.mute_toggle = 1'b1;
      `IRPIC_CODE_VOL_THIRD: d.volume_level_third = 1'b1;
      `IRPIC_CODE_BRT_HALF: d.brightness_level_half = 1'b1;
      `IRPIC_CODE_SAT_HALF: d.saturation_half = 1'b1;
      `IRPIC_CODE_CALL: d.call_toggle = 1'b1;
      `IRPIC_CODE_POWER: d.power_toggle = 1'b1;
      default: d.channel_load = c[`IRPIC_DIRECT_BIT] && !c[`IRPIC_HIGH_BIT];
    endcase
    return d;
  endfunction

  // Keeps only level steps, which repeat while the key stays held.
  function automatic irpic_pkg::irpic_cmd_t step_only(input irpic_pkg::irpic_cmd_t d);
    irpic_pkg::irpic_cmd_t s;
    s = '0;
    s.volume_level_up = d.volume_level_up;
    s.volume_level_down = d.volume_level_down;
    s.brightness_level_up = d.brightness_level_up;
    s.brightness_level_down = d.brightness_level_down;
    s.saturation_up = d.saturation_up;
    s.saturation_down = d.saturation_down;
    return s;
  endfunction

  // Repeat check and command execution. Toggles act once per key press, since
  // acting on every repeat would make them flicker while the key is held.
  always_comb begin
    irpic_pkg::irpic_cmd_t d;
    d = decode_cmd(word.code);
    next_st = st;
    next_st.cmd = '0;
    if (st.hold_cnt < HOLD) begin
      next_st.hold_cnt = st.hold_cnt + 1'b1;
    end else begin
      next_st.match_cnt = '0;
      next_st.indicator = 1'b0;
    end
    if (word.valid && word.code != `IRPIC_CODE_NONE) begin
      next_st.hold_cnt = '0;
      if (word.code == st.last_code) begin
        if (st.match_cnt != 2'h3) begin
          next_st.match_cnt = st.match_cnt + 1'b1;
        end
        if (st.match_cnt == 2'h2) begin
          next_st.indicator = 1'b1;
          next_st.cmd = d;
          if (d.channel_load) begin
            next_st.channel = word.code[3:0];
          end
          next_st.mute = st.mute ^ d.mute_toggle;
          next_st.call = st.call ^ d.call_toggle;
          next_st.power = st.power ^ d.power_toggle;
        end else if (st.match_cnt == 2'h3) begin
          next_st.cmd = step_only(d);
        end
      end else begin
        next_st.last_code = word.code;
        next_st.match_cnt = 2'h1;
        next_st.indicator = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign cmd_o = st.cmd;
  assign channel_o = st.channel;
  assign mute_o = st.mute;
  assign call_o = st.call;
  assign power_o = st.power;
  assign reception_indicator_o = st.indicator;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_third(logic [`IRPIC_CODE_W-1:0] c);
    word.valid && word.code == c && st.last_code == c && st.match_cnt == 2'h2;
  endsequence

  sequence s_new_code;
    word.valid && word.code != `IRPIC_CODE_NONE && word.code != st.last_code;
  endsequence

  sequence s_repeat(logic [`IRPIC_CODE_W-1:0] c);
    word.valid && word.code == c && st.last_code == c && st.match_cnt == 2'h3;
  endsequence

  a_new_code_quiet: assert property (s_new_code |=> cmd_o == '0 && !reception_indicator_o)
    else $error("Command acted before three identical codes.");

  a_zero_ignored: assert property (
    word.valid && word.code == `IRPIC_CODE_NONE |=> cmd_o == '0 && $stable(st.last_code))
    else $error("All-zero code had an effect.");

  a_chan_up: assert property (s_third(`IRPIC_CODE_CHAN_INC) |=> cmd_o.channel_increment)
    else $error("Channel up not issued on third match.");

  a_chan_down: assert property (
    s_third(`IRPIC_CODE_CHAN_DEC) |=> cmd_o.channel_decrement)
    else $error("Channel down not issued on third match.");

  a_vol_step: assert property (
    s_third(`IRPIC_CODE_VOL_UP) |=> cmd_o.volume_level_up ##1 !cmd_o.volume_level_up)
    else $error("Volume step not issued as a single pulse.");

  a_mute_toggle: assert property (s_third(`IRPIC_CODE_MUTE) |=> mute_o != $past(mute_o))
    else $error("Mute did not toggle.");

  a_vol_norm: assert property (
    s_third(`IRPIC_CODE_VOL_THIRD) |=> cmd_o.volume_level_third)
    else $error("Volume normalization not issued.");

  a_call_toggle: assert property (s_third(`IRPIC_CODE_CALL) |=> call_o != $past(call_o))
    else $error("Call output did not toggle.");

  a_power_toggle: assert property (
    s_third(`IRPIC_CODE_POWER) |=> power_o != $past(power_o))
    else $error("Power output did not toggle.");

  a_step_repeat: assert property (
    s_repeat(`IRPIC_CODE_VOL_UP) |=> cmd_o.volume_level_up)
    else $error("Held volume step did not repeat.");

  a_toggle_once: assert property (
    s_repeat(`IRPIC_CODE_POWER) |=> !cmd_o.power_toggle && $stable(power_o))
    else $error("Power toggled again on a repeated word.");

  a_direct_channel: assert property (
    word.valid && word.code[`IRPIC_DIRECT_BIT] && !word.code[`IRPIC_HIGH_BIT]
      && word.code == st.last_code && st.match_cnt == 2'h2
      |=> cmd_o.channel_load && channel_o == $past(word.code[3:0]))
    else $error("Direct channel not loaded.");

  a_indicator_rise: assert property (
    $rose(reception_indicator_o) |-> $past(word.valid) && st.match_cnt == 2'h3)
    else $error("Indicator rose without a third identical code.");

endmodule // irpic_receiver

// ==== tb/irpic_tx_model.sv ====
`timescale 1ns/10ps

module irpic_tx_model #(
  parameter int PULSE_CYC = 12,
  parameter int ZERO_CYC = 50,
  parameter int ONE_CYC = 100,
  parameter int SHORT_CYC = 20,
  parameter int WORD_CYC = 1200
) (
  // Clock.
  input wire logic ref_clk_i,
  // Word request from the bench.
  input wire logic go_i,
  input wire logic [5:0] code_i,
  input wire logic [2:0] nint_i,
  input wire logic short_i,
  // Envelope towards the receiver and busy flag.
  output logic pulse_o,
  output logic busy_o
);
  int gap;
  int used;

  // Sends one word, then idles to the end of the repeat period, so requests
  // back to back still keep the fixed word spacing of a held key.
  initial begin
    pulse_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      do @(posedge ref_clk_i); while (go_i !== 1'b1);
      busy_o <= 1'b1;
      used = 0;
      for (int i = 0; i <= int'(nint_i); i++) begin
        pulse_o <= 1'b1;
        repeat (PULSE_CYC) @(posedge ref_clk_i);
        pulse_o <= 1'b0;
        if (i < int'(nint_i)) begin
          gap = (i > 5) ? ONE_CYC : (code_i[i] ? ONE_CYC : ZERO_CYC);
          if (i == 0 && short_i) gap = SHORT_CYC;
          repeat (gap - PULSE_CYC) @(posedge ref_clk_i);
          used += gap;
        end
      end
      repeat (WORD_CYC - used - PULSE_CYC) @(posedge ref_clk_i);
      busy_o <= 1'b0;
    end
  end
endmodule // irpic_tx_model

// ==== tb/ir_pulse_interval_command_receiver_tb_top.sv ====
`timescale 1ns/10ps

module ir_pulse_interval_command_receiver_tb_top;
  // One decode case: code, command pulse, then channel and mute, call, power.
  typedef struct packed {
    logic [5:0] code;
    logic [14:0] cmd;
    logic [3:0] chan;
    logic [2:0] mcp;
  } irpic_row_t;

  logic ref_clk_i, sys_rst_i, go, short_word, pulse, busy;
  logic [5:0] code;
  logic [2:0] nint;
  irpic_pkg::irpic_cmd_t cmd, acc;
  logic [3:0] channel;
  logic mute, call, power, ind;
  logic [7:0] levels;
  int npulse, err_total, samples_checked, cycles;
  irpic_row_t rows [16] = '{
    '{6'h01, 15'h4000, 4'h0, 3'b000}, '{6'h02, 15'h2000, 4'h0, 3'b000},
    '{6'h03, 15'h0800, 4'h0, 3'b000}, '{6'h04, 15'h0400, 4'h0, 3'b000},
    '{6'h05, 15'h0200, 4'h0, 3'b000}, '{6'h06, 15'h0100, 4'h0, 3'b000},
    '{6'h07, 15'h0080, 4'h0, 3'b000}, '{6'h08, 15'h0040, 4'h0, 3'b000},
    '{6'h0a, 15'h0020, 4'h0, 3'b000}, '{6'h0b, 15'h0010, 4'h0, 3'b000},
    '{6'h0c, 15'h0008, 4'h0, 3'b000}, '{6'h09, 15'h0004, 4'h0, 3'b100},
    '{6'h0d, 15'h0002, 4'h0, 3'b110}, '{6'h0e, 15'h0001, 4'h0, 3'b111},
    '{6'h1f, 15'h1000, 4'hf, 3'b111}, '{6'h15, 15'h1000, 4'h5, 3'b111}};
  // Words that must never act: zero code, short interval, five and seven intervals.
  logic [5:0] bad_code [4] = '{6'h00, 6'h0e, 6'h0e, 6'h0e};
  logic [2:0] bad_n [4] = '{3'h6, 3'h6, 3'h5, 3'h7};
  logic bad_s [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

  // Held levels in one word: channel, then mute, call, power and indicator.
  assign levels = {channel, mute, call, power, ind};

  // Timing scaled by 400 so a full run fits the cycle budget.
  irpic_receiver #(.OSC_KHZ(192000)) DUT (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pulse_in_i(pulse), .cmd_o(cmd),
    .channel_o(channel), .mute_o(mute), .call_o(call), .power_o(power),
    .reception_indicator_o(ind));

  irpic_tx_model u_tx (.ref_clk_i(ref_clk_i), .go_i(go), .code_i(code), .nint_i(nint),
    .short_i(short_word), .pulse_o(pulse), .busy_o(busy));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // Collects every command pulse at the falling edge, where the outputs have
  // settled, so a missing or doubled one is seen.
  always @(negedge ref_clk_i) begin
    cycles++;
    if (cmd !== '0) begin
      acc = acc | cmd;
      npulse++;
    end
    if (cycles == 100000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // Hands one word to the transmitter and returns once its period is over.
  task automatic send(input logic [5:0] c, input logic [2:0] n, input logic s);
    code = c;
    nint = n;
    short_word = s;
    go = 1'b1;
    wait (busy === 1'b1);
    @(posedge ref_clk_i);
    #1 go = 1'b0;
    wait (busy === 1'b0);
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic clr();
    acc = '0;
    npulse = 0;
  endtask

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Table of codes first, then refusals, a broken run, repeats and a late reset.
  initial begin
    sys_rst_i = 1'b1;
    {go, short_word, code, nint, acc} = '0;
    {npulse, err_total, samples_checked, cycles} = '0;
    repeat (4) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    chk("levels after reset", 16'h0, {channel, mute, call, power, ind});
    foreach (rows[r]) begin
      clr();
      send(rows[r].code, 3'h6, 1'b0);
      chk("indicator after first word", 16'h0, ind);
      send(rows[r].code, 3'h6, 1'b0);
      chk("command before third word", 16'h0, acc);
      send(rows[r].code, 3'h6, 1'b0);
      chk("command", rows[r].cmd, acc);
      chk("pulse count", 16'h1, npulse[15:0]);
      chk("levels", {rows[r].chan, rows[r].mcp, 1'b1}, levels);
    end
    for (int k = 0; k < 4; k++) begin
      clr();
      repeat (3) send(bad_code[k], bad_n[k], bad_s[k]);
      chk("refused word", 16'h0, acc);
    end
    chk("indicator after silence", 16'h0, ind);
    clr();
    repeat (2) send(6'h0e, 3'h6, 1'b0);
    send(6'h0d, 3'h6, 1'b0);
    repeat (2) send(6'h0e, 3'h6, 1'b0);
    chk("command after broken run", 16'h0, acc);
    repeat (2) send(6'h0e, 3'h6, 1'b0);
    chk("toggle once per press", 16'h0001, acc);
    chk("toggle pulse count", 16'h1, npulse[15:0]);
    chk("power level", 16'h0, power);
    clr();
    repeat (4) send(6'h03, 3'h6, 1'b0);
    chk("step repeats", 16'h0800, acc);
    chk("step pulse count", 16'h2, npulse[15:0]);
    sys_rst_i = 1'b1;
    @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    chk("levels after second reset", 16'h0, {channel, mute, call, power, ind});
    stop_test();
  end
endmodule // ir_pulse_interval_command_receiver_tb_top
